// ### smbus_blk_cfg.svh
`ifndef SMBUS_BLK_CFG_SVH
`define SMBUS_BLK_CFG_SVH

// Bit counter positions within one byte frame on the link
`define SMB_BIT_FIRST   4'h0
`define SMB_BIT_LAST    4'h7
`define SMB_BIT_ACK     4'h8

// Direction bit value for a write request
`define SMB_DIR_WRITE   1'b0

// Byte and word geometry
`define SMB_BYTE_W      8
`define SMB_ADDR_W      7
`define SMB_FIFO_DEPTH  4

// Strap level codes
`define SMB_STRAP_LOW   2'h0
`define SMB_STRAP_MID   2'h1

// Default bus addresses per strap level
`define SMB_ADDR_LOW    7'h10
`define SMB_ADDR_MID    7'h11
`define SMB_ADDR_HIGH   7'h12

`endif

// ### smbus_blk_pkg.sv
`default_nettype none

package smbus_blk_pkg;

    typedef enum logic [4:0] {
        S_ADDR   = 5'h01,
        S_INDEX  = 5'h02,
        S_COUNT  = 5'h04,
        S_DATA   = 5'h08,
        S_IGNORE = 5'h10
    } link_state_t;

endpackage : smbus_blk_pkg

`default_nettype wire

// ### bit_sync.sv
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
    parameter int W = 1
) (
    // Destination clock
    input  wire logic         clk_i,
    // Level crossing in and out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage is read only by the second
    always_ff @(posedge clk_i) begin
        meta_q <= d_i;
        sync_q <= meta_q;
    end

    assign q_o = sync_q;

endmodule : bit_sync

`default_nettype wire

// ### xclk_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module xclk_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Write side
    input  wire logic             wr_clk_i,
    input  wire logic             wr_clr_i,
    input  wire logic             wr_valid_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    output logic                  wr_ready_o,
    // Read side
    input  wire logic             rd_clk_i,
    input  wire logic             rd_rst_i,
    output logic                  rd_valid_o,
    output logic      [WIDTH-1:0] rd_data_o,
    input  wire logic             rd_ready_i
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wbin_q;
    logic [AW:0]      wgray_q;
    logic [AW:0]      rbin_q;
    logic [AW:0]      rgray_q;
    logic [AW:0]      wgray_s;
    logic [AW:0]      rgray_s;
    logic [AW:0]      wbin_n;
    logic [AW:0]      rbin_n;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : to_gray

    assign wbin_n = wbin_q + 1'b1;
    assign rbin_n = rbin_q + 1'b1;

    // Full is pessimistic: read pointer arrives two write edges late
    assign wr_ready_o = (wgray_q != {~rgray_s[AW:AW-1], rgray_s[AW-2:0]});
    assign rd_valid_o = (rgray_q != wgray_s);
    assign rd_data_o  = mem_q[rbin_q[AW-1:0]];

    // Write clock may stop between frames, so its clear is asynchronous
    always_ff @(posedge wr_clk_i or posedge wr_clr_i) begin
        if (wr_clr_i) begin
            wbin_q  <= '0;
            wgray_q <= '0;
        end else if (wr_valid_i && wr_ready_o) begin
            wbin_q  <= wbin_n;
            wgray_q <= to_gray(wbin_n);
        end
    end

    always_ff @(posedge wr_clk_i) begin
        if (wr_valid_i && wr_ready_o) begin
            mem_q[wbin_q[AW-1:0]] <= wr_data_i;
        end
    end

    always_ff @(posedge rd_clk_i) begin
        if (rd_rst_i) begin
            rbin_q  <= '0;
            rgray_q <= '0;
        end else if (rd_valid_o && rd_ready_i) begin
            rbin_q  <= rbin_n;
            rgray_q <= to_gray(rbin_n);
        end
    end

    bit_sync #(.W(AW + 1)) u_wptr_sync (
        .clk_i (rd_clk_i),
        .d_i   (wgray_q),
        .q_o   (wgray_s)
    );

    bit_sync #(.W(AW + 1)) u_rptr_sync (
        .clk_i (wr_clk_i),
        .d_i   (rgray_q),
        .q_o   (rgray_s)
    );

endmodule : xclk_fifo

`default_nettype wire

// ### smbus_indexed_block_write_target.sv
`include "smbus_blk_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module smbus_indexed_block_write_target #(
    parameter logic [6:0] ADDR_LOW   = `SMB_ADDR_LOW,
    parameter logic [6:0] ADDR_MID   = `SMB_ADDR_MID,
    parameter logic [6:0] ADDR_HIGH  = `SMB_ADDR_HIGH,
    parameter int         FIFO_DEPTH = `SMB_FIFO_DEPTH
) (
    // System clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    // Two-wire link
    input  wire logic       scl_link_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    // Address strap
    input  wire logic [1:0] address_select_strap_i,
    // Register write stream
    output logic            rx_valid_o,
    output logic      [7:0] rx_index_o,
    output logic      [7:0] rx_data_o,
    input  wire logic       rx_ready_i,
    // Status
    output logic            frame_active_o,
    output logic      [6:0] own_addr_o
);

    localparam int BW = `SMB_BYTE_W;

    // System domain
    logic [3:0]  pins_s;
    logic        scl_s;
    logic        sda_s;
    logic [1:0]  strap_s;
    logic        sda_p_q;
    logic        start_w;
    logic        stop_w;
    logic        link_clr_q;
    logic        restart_q;
    logic        link_rst_q;
    logic        frame_active_q;
    logic        strap_taken_q;
    logic [6:0]  own_addr_q;
    logic        sda_o_q;
    logic        rx_valid_q;
    logic [7:0]  rx_index_q;
    logic [7:0]  rx_data_q;
    logic        fifo_rd_valid;
    logic [15:0] fifo_rd_data;
    logic        pop_w;

    // Link domain
    smbus_blk_pkg::link_state_t state_q;
    logic [3:0]  bit_cnt_q;
    logic [6:0]  shift_q;
    logic        ack_q;
    logic [7:0]  idx_q;
    logic [7:0]  cnt_q;
    logic        sda_oe_n_q;
    logic [7:0]  byte_w;
    logic        byte_done;
    logic        addr_hit;
    logic        want_w;
    logic        push_w;
    logic        fifo_wr_ready;

    function automatic logic [6:0] strap_addr(input logic [1:0] code);
        logic [6:0] a;
        a = ADDR_HIGH;
        if (code == `SMB_STRAP_LOW) begin
            a = ADDR_LOW;
        end else if (code == `SMB_STRAP_MID) begin
            a = ADDR_MID;
        end
        return a;
    endfunction : strap_addr

    bit_sync #(.W(4)) u_pin_sync (
        .clk_i (clk_sys_i),
        .d_i   ({scl_link_i, sda_i, address_select_strap_i}),
        .q_o   (pins_s)
    );

    assign scl_s   = pins_s[3];
    assign sda_s   = pins_s[2];
    assign strap_s = pins_s[1:0];

    // Oversampled pins give the frame boundaries the link clock cannot see
    assign start_w = scl_s && sda_p_q && !sda_s;
    assign stop_w  = scl_s && !sda_p_q && sda_s;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            sda_p_q <= 1'b1;
        end else begin
            sda_p_q <= sda_s;
        end
    end

    // Link logic held clear outside frames; repeated start re-clears it
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            link_clr_q <= 1'b1;
            restart_q  <= 1'b0;
        end else if (stop_w) begin
            link_clr_q <= 1'b1;
            restart_q  <= 1'b0;
        end else if (start_w && !link_clr_q) begin
            link_clr_q <= 1'b1;
            restart_q  <= 1'b1;
        end else if (start_w || restart_q) begin
            link_clr_q <= 1'b0;
            restart_q  <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            link_rst_q     <= 1'b1;
            frame_active_q <= 1'b0;
            sda_o_q        <= 1'b0;
        end else begin
            link_rst_q     <= 1'b0;
            frame_active_q <= !link_clr_q;
            sda_o_q        <= 1'b0;
        end
    end

    // Strap taken once after reset; later strap changes are ignored
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            strap_taken_q <= 1'b0;
            own_addr_q    <= ADDR_LOW;
        end else if (!strap_taken_q) begin
            strap_taken_q <= 1'b1;
            own_addr_q    <= strap_addr(strap_s);
        end
    end

    // Link side: SDA is launched by the host against SCL, so SCL samples it
    assign byte_w    = {shift_q, sda_i};
    assign byte_done = (bit_cnt_q == `SMB_BIT_LAST);
    // Address is quasi-static: latched long before any frame
    assign addr_hit  = (byte_w[7:1] == own_addr_q) && (byte_w[0] == `SMB_DIR_WRITE);
    assign want_w    = byte_done && (state_q == smbus_blk_pkg::S_DATA) && (cnt_q != 8'h00);
    assign push_w    = want_w && fifo_wr_ready;

    always_ff @(posedge scl_link_i or posedge link_clr_q) begin
        if (link_clr_q) begin
            bit_cnt_q <= `SMB_BIT_FIRST;
            shift_q   <= '0;
        end else begin
            shift_q   <= byte_w[6:0];
            if (bit_cnt_q == `SMB_BIT_ACK) begin
                bit_cnt_q <= `SMB_BIT_FIRST;
            end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge scl_link_i or posedge link_clr_q) begin
        if (link_clr_q) begin
            state_q <= smbus_blk_pkg::S_ADDR;
            ack_q   <= 1'b0;
        end else if (byte_done) begin
            unique case (state_q)
                smbus_blk_pkg::S_ADDR: begin
                    if (addr_hit) begin
                        state_q <= smbus_blk_pkg::S_INDEX;
                        ack_q   <= 1'b1;
                    end else begin
                        state_q <= smbus_blk_pkg::S_IGNORE;
                        ack_q   <= 1'b0;
                    end
                end
                smbus_blk_pkg::S_INDEX: begin
                    state_q <= smbus_blk_pkg::S_COUNT;
                    ack_q   <= 1'b1;
                end
                smbus_blk_pkg::S_COUNT: begin
                    state_q <= smbus_blk_pkg::S_DATA;
                    ack_q   <= 1'b1;
                end
                smbus_blk_pkg::S_DATA: begin
                    // Full buffer or surplus byte: refuse, host sees no acknowledge
                    if (push_w) begin
                        ack_q   <= 1'b1;
                    end else begin
                        state_q <= smbus_blk_pkg::S_IGNORE;
                        ack_q   <= 1'b0;
                    end
                end
                smbus_blk_pkg::S_IGNORE: begin
                    ack_q <= 1'b0;
                end
                default: begin
                    state_q <= smbus_blk_pkg::S_IGNORE;
                    ack_q   <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge scl_link_i or posedge link_clr_q) begin
        if (link_clr_q) begin
            idx_q <= 8'h00;
            cnt_q <= 8'h00;
        end else if (byte_done && state_q == smbus_blk_pkg::S_INDEX) begin
            idx_q <= byte_w;
        end else if (byte_done && state_q == smbus_blk_pkg::S_COUNT) begin
            cnt_q <= byte_w;
        end else if (push_w) begin
            idx_q <= 8'(idx_q + 8'h01);
            cnt_q <= 8'(cnt_q - 8'h01);
        end
    end

    // Acknowledge driven from the falling edge so SDA is steady at the rise
    always_ff @(negedge scl_link_i or posedge link_clr_q) begin
        if (link_clr_q) begin
            sda_oe_n_q <= 1'b1;
        end else begin
            sda_oe_n_q <= !((bit_cnt_q == `SMB_BIT_ACK) && ack_q);
        end
    end

    xclk_fifo #(.WIDTH(2 * BW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .wr_clk_i   (scl_link_i),
        .wr_clr_i   (link_rst_q),
        .wr_valid_i (want_w),
        .wr_data_i  ({idx_q, byte_w}),
        .wr_ready_o (fifo_wr_ready),
        .rd_clk_i   (clk_sys_i),
        .rd_rst_i   (sys_rst_i),
        .rd_valid_o (fifo_rd_valid),
        .rd_data_o  (fifo_rd_data),
        .rd_ready_i (pop_w)
    );

    assign pop_w = fifo_rd_valid && (!rx_valid_q || rx_ready_i);

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rx_valid_q <= 1'b0;
            rx_index_q <= 8'h00;
            rx_data_q  <= 8'h00;
        end else if (pop_w) begin
            rx_valid_q <= 1'b1;
            rx_index_q <= fifo_rd_data[15:8];
            rx_data_q  <= fifo_rd_data[7:0];
        end else if (rx_ready_i) begin
            rx_valid_q <= 1'b0;
        end
    end

    assign sda_o          = sda_o_q;
    assign sda_oe_n_o     = sda_oe_n_q;
    assign rx_valid_o     = rx_valid_q;
    assign rx_index_o     = rx_index_q;
    assign rx_data_o      = rx_data_q;
    assign frame_active_o = frame_active_q;
    assign own_addr_o     = own_addr_q;

    a_addr_ack_match: assert property (
        @(posedge scl_link_i) disable iff (link_clr_q)
        (byte_done && state_q == smbus_blk_pkg::S_ADDR && addr_hit)
        |=> (ack_q && state_q == smbus_blk_pkg::S_INDEX))
        else $error("matching address not acknowledged");

    a_index_load: assert property (
        @(posedge scl_link_i) disable iff (link_clr_q)
        (byte_done && state_q == smbus_blk_pkg::S_INDEX)
        |=> (idx_q == $past(byte_w) && ack_q && state_q == smbus_blk_pkg::S_COUNT))
        else $error("start index not loaded");

    a_count_ack: assert property (
        @(posedge scl_link_i) disable iff (link_clr_q)
        (byte_done && state_q == smbus_blk_pkg::S_COUNT)
        |=> (cnt_q == $past(byte_w) && ack_q))
        else $error("count byte not taken");

    a_index_step: assert property (
        @(posedge scl_link_i) disable iff (link_clr_q)
        push_w |=> (idx_q == 8'($past(idx_q) + 8'h01) && cnt_q == 8'($past(cnt_q) - 8'h01)))
        else $error("index did not advance by one");

    a_ack_drive: assert property (
        @(negedge scl_link_i) disable iff (link_clr_q)
        (bit_cnt_q == `SMB_BIT_ACK && ack_q) |=> !sda_oe_n_q ##1 sda_oe_n_q)
        else $error("acknowledge slot not driven for one bit");

    a_strap_hold: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        strap_taken_q |=> $stable(own_addr_q))
        else $error("latched address changed");

    a_miss_release: assert property (
        @(posedge scl_link_i) disable iff (link_clr_q)
        (byte_done && state_q == smbus_blk_pkg::S_ADDR && !addr_hit)
        |=> (!ack_q && state_q == smbus_blk_pkg::S_IGNORE))
        else $error("foreign address not ignored");

    a_stop_clear: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        stop_w |=> link_clr_q ##1 !frame_active_q)
        else $error("stop did not end the frame");

    c_addr_ack: cover property (
        @(posedge scl_link_i) disable iff (link_clr_q)
        byte_done && state_q == smbus_blk_pkg::S_ADDR && addr_hit);

    c_data_push: cover property (
        @(posedge scl_link_i) disable iff (link_clr_q) push_w);

    c_full_refuse: cover property (
        @(posedge scl_link_i) disable iff (link_clr_q) want_w && !fifo_wr_ready);

endmodule : smbus_indexed_block_write_target

`default_nettype wire

// ### smbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module smbus_host_model (
    // Link drive, open drain on data
    output logic      scl_o,
    output logic      sda_low_o,
    // Resolved data line
    input  wire logic sda_i
);
    localparam int HALF = 80;

    // Clock stands high between frames
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // Works from idle and as a repeated start
    task automatic start_cond;
        #(HALF / 2) sda_low_o = 1'b0;
        #(HALF / 2) scl_o = 1'b1;
        #(HALF) sda_low_o = 1'b1;
        #(2 * HALF) scl_o = 1'b0;
    endtask : start_cond

    // Address, index, count and data bytes alike, MSB first
    task automatic write_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #(HALF / 2) sda_low_o = ~b[i];
            #(HALF / 2) scl_o = 1'b1;
            #(HALF) scl_o = 1'b0;
        end
        #(HALF / 2) sda_low_o = 1'b0;
        #(HALF / 2) scl_o = 1'b1;
        #(HALF / 2) ack = ~sda_i;
        #(HALF / 2) scl_o = 1'b0;
    endtask : write_byte

    task automatic stop_cond;
        #(HALF / 2) sda_low_o = 1'b1;
        #(HALF / 2) scl_o = 1'b1;
        #(HALF) sda_low_o = 1'b0;
        #(4 * HALF);
    endtask : stop_cond
endmodule : smbus_host_model

`default_nettype wire

// ### smbus_indexed_block_write_target_test.sv
`include "smbus_blk_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module smbus_indexed_block_write_target_test;
    logic        clk_sys_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        scl, sda_low, sda_line, sda_o, sda_oe_n_o;
    logic [1:0]  strap = 2'h0;
    logic        rx_valid_o, rx_ready_i = 1'b0, frame_active_o, stall = 1'b0;
    logic [7:0]  rx_index_o, rx_data_o;
    logic [6:0]  own_addr_o, exp_addr;
    logic [15:0] exp_q[$], got_q[$];
    int          err_count = 0, checks_done = 0, seed_v;

    // Pull-up on the data line
    assign sda_line = ~(sda_low | ~sda_oe_n_o);

    always #12.5 clk_sys_i = ~clk_sys_i;

    smbus_host_model host (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_line));

    smbus_indexed_block_write_target #(
        .ADDR_LOW(`SMB_ADDR_LOW), .ADDR_MID(`SMB_ADDR_MID),
        .ADDR_HIGH(`SMB_ADDR_HIGH), .FIFO_DEPTH(`SMB_FIFO_DEPTH)
    ) DUT (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .scl_link_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .address_select_strap_i(strap), .rx_valid_o(rx_valid_o),
        .rx_index_o(rx_index_o), .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i),
        .frame_active_o(frame_active_o), .own_addr_o(own_addr_o)
    );

    always @(posedge clk_sys_i) begin
        if (!sys_rst_i && rx_valid_o === 1'b1 && rx_ready_i)
            got_q.push_back({rx_index_o, rx_data_o});
        #1 rx_ready_i = ~stall & 1'($urandom_range(0, 1));
    end

    task automatic stop_test;
        if (err_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task automatic do_reset(input logic [1:0] code);
        @(posedge clk_sys_i) #1 sys_rst_i = 1'b1;
        strap = code;
        exp_addr = (code == 2'h0) ? `SMB_ADDR_LOW : (code == 2'h1) ? `SMB_ADDR_MID : `SMB_ADDR_HIGH;
        repeat (8) @(posedge clk_sys_i);
        #1 sys_rst_i = 1'b0;
        `CHECK({sda_oe_n_o, sda_o, rx_valid_o, frame_active_o}, 4'h8)
        repeat (6) @(posedge clk_sys_i);
        #1 `CHECK(own_addr_o, exp_addr)
    endtask : do_reset

    // Ready is let loose, then every stored byte is compared in order
    task automatic drain;
        int          t;
        logic [15:0] got_v;
        logic [15:0] exp_v;
        stall = 1'b0;
        for (t = 0; t < 2000 && got_q.size() < exp_q.size(); t++) @(posedge clk_sys_i);
        if (t >= 2000) begin
            err_count++;
            stop_test();
        end else begin
            repeat (40) @(posedge clk_sys_i);
            `CHECK(got_q.size(), exp_q.size())
            // Popped once each: the compare macro reads its arguments twice
            while (got_q.size() != 0 && exp_q.size() != 0) begin
                got_v = got_q.pop_front();
                exp_v = exp_q.pop_front();
                `CHECK(got_v, exp_v)
            end
            got_q.delete();
            exp_q.delete();
            // Next start kept off the system clock edges
            #1;
        end
    endtask : drain

    // Beyond the fifo depth a loose frame may refuse, once and for good
    task automatic frame(input logic [6:0] a, input logic rw, input logic [7:0] n, x,
                         input int nb, input bit loose);
        logic       ack, match;
        logic [7:0] d;
        int         nacks;
        match = (a == exp_addr) && !rw;
        nacks = 0;
        host.start_cond();
        host.write_byte({a, rw}, ack);
        `CHECK(ack, match)
        `CHECK(frame_active_o, 1'b1)
        host.write_byte(n, ack);
        `CHECK(ack, match)
        host.write_byte(x, ack);
        `CHECK(ack, match)
        for (int k = 0; k < nb; k++) begin
            d = 8'($urandom);
            host.write_byte(d, ack);
            if (!(loose && k >= `SMB_FIFO_DEPTH && nacks == 0))
                `CHECK(ack, match && k < int'(x) && nacks == 0)
            if (ack === 1'b1)
                exp_q.push_back({n + 8'(k), d});
            else
                nacks++;
        end
        if (loose) `CHECK(nacks != 0, 1'b1)
        host.stop_cond();
        `CHECK({frame_active_o, sda_oe_n_o}, 2'h1)
        drain();
    endtask : frame

    initial begin
        seed_v = $urandom(32'hf739);
        for (int c = 0; c < 4; c++) begin
            do_reset(2'(c));
            frame(exp_addr, 1'b0, 8'($urandom), 8'h01, 1, 1'b0);
        end
        strap = 2'h0;
        repeat (20) @(posedge clk_sys_i);
        #1 `CHECK(own_addr_o, exp_addr)
        for (int i = 0; i < 3; i++)
            frame(exp_addr, 1'b0, 8'($urandom), 8'($urandom_range(1, 4)), 4, 1'b0);
        frame(exp_addr, 1'b0, 8'hfe, 8'h03, 3, 1'b0);
        frame(exp_addr, 1'b0, 8'($urandom), 8'h02, 4, 1'b0);
        frame(exp_addr, 1'b0, 8'($urandom), 8'h00, 1, 1'b0);
        frame(exp_addr ^ 7'h01, 1'b0, 8'h10, 8'h02, 2, 1'b0);
        frame(exp_addr, 1'b1, 8'h20, 8'h02, 2, 1'b0);
        host.start_cond();
        host.write_byte({exp_addr, `SMB_DIR_WRITE}, seed_v[0]);
        frame(exp_addr, 1'b0, 8'h40, 8'h02, 2, 1'b0);
        stall = 1'b1;
        frame(exp_addr, 1'b0, 8'($urandom), 8'h08, 8, 1'b1);
        stop_test();
    end
endmodule : smbus_indexed_block_write_target_test

`default_nettype wire
